// ==== prc_pkg.sv ====
package prc_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int RAILS    = 6;
  localparam int VID_W    = 7;
  localparam int RAIL_IDX = 3;
  localparam int PINS     = 12;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ      = 200000;
  localparam int OFF_DLY_MS   = 4;
  localparam int OFF_DLY_CYC  = OFF_DLY_MS * CLK_KHZ;

  // Rails whose turn-off waits for the cascade delay
  localparam logic [RAILS-1:0] DLY_RAIL_MASK = 6'h06;
  // Rail that follows the sleep input
  localparam int SLEEP_RAIL = 5;

  // ----------------------------------------------------------------
  // Step ranges and reset values
  // ----------------------------------------------------------------
  localparam logic STEP_10MV = 1'b0;
  localparam logic STEP_25MV = 1'b1;
  localparam logic FORCE_PWM_RST = 1'b0;
  localparam logic [VID_W-1:0] VID_DEF = 7'h3C;
  localparam logic [VID_W-1:0] VID_SLP_DEF = 7'h30;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic             force_pwm;
    logic [VID_W-1:0] vid;
  } prc_rail_cfg_s;

  typedef struct packed {
    logic lin_a_one_en;
    logic lin_a_two_en;
    logic lin_a_three_en;
    logic switch_b_two_en;
    logic general_output_3_release;
    logic general_output_4_release;
  } prc_aux_s;

  localparam prc_aux_s AUX_RST = '0;

endpackage

// ==== prc_sequencer.sv ====
`timescale 1ns/1ps
module prc_sequencer #(
  parameter int                                   OFF_DLY_CYC =
    prc_pkg::OFF_DLY_CYC,
  parameter logic [prc_pkg::RAILS-1:0]            STEP_RANGE  = '0,
  parameter logic [prc_pkg::RAILS*prc_pkg::VID_W-1:0] DEF_VID =
    {prc_pkg::RAILS{prc_pkg::VID_DEF}},
  parameter logic [prc_pkg::RAILS*prc_pkg::VID_W-1:0] SLP_VID =
    {prc_pkg::RAILS{prc_pkg::VID_SLP_DEF}}
) (
  // Clock and reset
  input  wire logic                          i_clk,
  input  wire logic                          i_rst,
  // Control pins, asynchronous
  input  wire logic                          i_control_input_1,
  input  wire logic                          i_control_input_2,
  input  wire logic                          i_control_input_3,
  input  wire logic                          i_control_input_4,
  input  wire logic                          i_control_input_5,
  input  wire logic                          i_sleep_control_input,
  // Rail power-good, asynchronous, bit 0 is rail 1
  input  wire logic [prc_pkg::RAILS-1:0]     i_rail_pgood,
  // Rail configuration write
  input  wire logic                          i_cfg_wr,
  input  wire logic [prc_pkg::RAIL_IDX-1:0]  i_cfg_rail,
  input  wire logic                          i_cfg_sleep,
  input  wire prc_pkg::prc_rail_cfg_s        i_cfg_data,
  // Auxiliary bit write
  input  wire logic                          i_aux_wr,
  input  wire prc_pkg::prc_aux_s             i_aux_data,
  // Switching rails
  output logic [prc_pkg::RAILS-1:0]          o_rail_en,
  output prc_pkg::prc_rail_cfg_s [prc_pkg::RAILS-1:0] o_rail_cfg,
  output logic [prc_pkg::RAILS-1:0]          o_rail_step,
  // Other regulators and switches
  output logic                               o_termination_regulator_en,
  output logic                               o_load_switch_a_one_en,
  output logic                               o_load_switch_b_one_en,
  output logic                               o_load_switch_b_two_en,
  output logic                               o_linear_reg_a_one_en,
  output logic                               o_linear_reg_a_two_en,
  output logic                               o_linear_reg_a_three_en,
  // General outputs, open drain, bit 0 is output 1
  output logic [3:0]                         o_general_output,
  output logic [3:0]                         o_general_output_oe,
  // Auxiliary register readback
  output prc_pkg::prc_aux_s                  o_aux
);

  localparam int CW = $clog2(OFF_DLY_CYC + 1);

  if (OFF_DLY_CYC < 1) begin : g_chk
    $error("OFF_DLY_CYC must be at least one cycle");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [prc_pkg::PINS-1:0] pin_meta;
  logic [prc_pkg::PINS-1:0] pin_sync;
  logic                     c1;
  logic                     c2;
  logic                     c3;
  logic                     c4;
  logic                     c5;
  logic                     c_sleep;
  logic [prc_pkg::RAILS-1:0] pg;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= {i_rail_pgood, i_sleep_control_input, i_control_input_5,
                   i_control_input_4, i_control_input_3, i_control_input_2,
                   i_control_input_1};
      pin_sync <= pin_meta;
    end
  end

  assign c1      = pin_sync[0];
  assign c2      = pin_sync[1];
  assign c3      = pin_sync[2];
  assign c4      = pin_sync[3];
  assign c5      = pin_sync[4];
  assign c_sleep = pin_sync[5];
  assign pg      = pin_sync[prc_pkg::PINS-1:6];

  // ----------------------------------------------------------------
  // Rail configuration registers
  // ----------------------------------------------------------------
  prc_pkg::prc_rail_cfg_s [prc_pkg::RAILS-1:0] rail_cfg;
  prc_pkg::prc_rail_cfg_s [prc_pkg::RAILS-1:0] next_rail_cfg;
  logic [prc_pkg::RAILS-1:0][prc_pkg::VID_W-1:0] slp_vid;
  logic [prc_pkg::RAILS-1:0][prc_pkg::VID_W-1:0] next_slp_vid;
  prc_pkg::prc_aux_s aux;
  prc_pkg::prc_aux_s next_aux;

  function automatic logic rail_hit(input logic [prc_pkg::RAIL_IDX-1:0] sel,
                                    input int idx);
    rail_hit = (int'(sel) == idx);
  endfunction

  always_comb begin
    next_rail_cfg = rail_cfg;
    next_slp_vid  = slp_vid;
    next_aux      = aux;
    for (int i = 0; i < prc_pkg::RAILS; i++) begin
      // Codes are taken whether the rail is on or off
      if (i_cfg_wr && rail_hit(i_cfg_rail, i)) begin
        if (i_cfg_sleep) begin
          next_slp_vid[i] = i_cfg_data.vid;
        end else begin
          next_rail_cfg[i] = i_cfg_data;
        end
      end
    end
    if (i_aux_wr) begin
      next_aux = i_aux_data;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < prc_pkg::RAILS; i++) begin
        rail_cfg[i].force_pwm <= prc_pkg::FORCE_PWM_RST;
        rail_cfg[i].vid <= DEF_VID[i*prc_pkg::VID_W +: prc_pkg::VID_W];
        slp_vid[i] <= SLP_VID[i*prc_pkg::VID_W +: prc_pkg::VID_W];
      end
      aux <= prc_pkg::AUX_RST;
    end else begin
      rail_cfg <= next_rail_cfg;
      slp_vid  <= next_slp_vid;
      aux      <= next_aux;
    end
  end

  // ----------------------------------------------------------------
  // Sequencing chain
  // ----------------------------------------------------------------
  logic [prc_pkg::RAILS-1:0]         cond;
  logic [prc_pkg::RAILS-1:0]         rail_en;
  logic [prc_pkg::RAILS-1:0]         next_rail_en;
  logic [prc_pkg::RAILS-1:0][CW-1:0] off_cnt;
  logic [prc_pkg::RAILS-1:0][CW-1:0] next_off_cnt;

  // Chain A hangs on input 1, chain B on input 2 and chain A power-good
  always_comb begin
    cond[0] = c1;
    cond[1] = c2 & pg[0];
    cond[2] = c2 & rail_en[1] & pg[1];
    cond[3] = c2 & pg[2];
    cond[4] = c2 & pg[3];
    cond[5] = c2 & pg[4];
  end

  // Each rail reacts to its own condition only, so chain B starts only after chain A power-good
  always_comb begin
    next_rail_en = rail_en;
    next_off_cnt = off_cnt;
    for (int i = 0; i < prc_pkg::RAILS; i++) begin
      if (cond[i]) begin
        next_rail_en[i] = 1'b1;
        next_off_cnt[i] = '0;
      end else if (rail_en[i]) begin
        if (!prc_pkg::DLY_RAIL_MASK[i] ||
            off_cnt[i] == CW'(OFF_DLY_CYC - 1)) begin
          next_rail_en[i] = 1'b0;
          next_off_cnt[i] = '0;
        end else begin
          next_off_cnt[i] = off_cnt[i] + CW'(1);
        end
      end else begin
        next_off_cnt[i] = '0;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rail_en <= '0;
      off_cnt <= '0;
    end else begin
      rail_en <= next_rail_en;
      off_cnt <= next_off_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  prc_pkg::prc_rail_cfg_s [prc_pkg::RAILS-1:0] next_out_cfg;
  logic [3:0] gpo_release;
  logic [3:0] next_gpo_release;
  logic [6:0] sw_en;
  logic [6:0] next_sw_en;

  always_comb begin
    next_out_cfg = rail_cfg;
    if (c_sleep) begin
      next_out_cfg[prc_pkg::SLEEP_RAIL].vid =
        slp_vid[prc_pkg::SLEEP_RAIL];
    end
    // Outputs 1 and 2 fall as soon as input 1 drops
    next_gpo_release[0] = c1 & pg[0];
    next_gpo_release[1] = c1 & pg[5];
    next_gpo_release[2] = aux.general_output_3_release;
    next_gpo_release[3] = aux.general_output_4_release;
    next_sw_en[0] = c3;
    next_sw_en[1] = c4;
    next_sw_en[2] = c4;
    next_sw_en[3] = c5 | aux.switch_b_two_en;
    next_sw_en[4] = aux.lin_a_one_en;
    next_sw_en[5] = aux.lin_a_two_en;
    next_sw_en[6] = aux.lin_a_three_en;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < prc_pkg::RAILS; i++) begin
        o_rail_cfg[i].force_pwm <= prc_pkg::FORCE_PWM_RST;
        o_rail_cfg[i].vid <= DEF_VID[i*prc_pkg::VID_W +: prc_pkg::VID_W];
      end
      gpo_release <= '0;
      sw_en       <= '0;
    end else begin
      o_rail_cfg  <= next_out_cfg;
      gpo_release <= next_gpo_release;
      sw_en       <= next_sw_en;
    end
  end

  assign o_rail_en                  = rail_en;
  assign o_rail_step                = STEP_RANGE;
  assign o_termination_regulator_en = sw_en[0];
  assign o_load_switch_a_one_en     = sw_en[1];
  assign o_load_switch_b_one_en     = sw_en[2];
  assign o_load_switch_b_two_en     = sw_en[3];
  assign o_linear_reg_a_one_en      = sw_en[4];
  assign o_linear_reg_a_two_en      = sw_en[5];
  assign o_linear_reg_a_three_en    = sw_en[6];
  assign o_general_output           = '0;
  assign o_general_output_oe        = ~gpo_release;
  assign o_aux                      = aux;

endmodule

// ==== prc_seq_assertions.sv ====
`timescale 1ns/1ps
module prc_seq_assertions #(
  parameter int OFF_DLY_CYC = 8
) (
  // Clock, reset and pins
  input wire logic                          i_clk,
  input wire logic                          i_rst,
  input wire logic                          i_control_input_1,
  input wire logic                          i_control_input_4,
  input wire logic                          i_control_input_5,
  // Writes
  input wire logic                          i_aux_wr,
  input wire prc_pkg::prc_aux_s             i_aux_data,
  input wire logic                          i_cfg_wr,
  input wire logic [2:0]                    i_cfg_rail,
  input wire logic                          i_cfg_sleep,
  input wire prc_pkg::prc_rail_cfg_s        i_cfg_data,
  // Outputs
  input wire logic [5:0]                    o_rail_en,
  input wire prc_pkg::prc_rail_cfg_s [5:0]  o_rail_cfg,
  input wire logic [5:0]                    o_rail_step,
  input wire logic                          o_load_switch_a_one_en,
  input wire logic                          o_load_switch_b_one_en,
  input wire logic                          o_load_switch_b_two_en,
  input wire logic                          o_linear_reg_a_two_en,
  input wire logic [3:0]                    o_general_output_oe,
  input wire prc_pkg::prc_aux_s             o_aux
);
  // ----------------------------------------------------------------
  // Cycles rail 3 stays on after rail 2 went off
  // ----------------------------------------------------------------
  int cnt;
  int next_cnt;
  always_comb next_cnt = (o_rail_en[2] && !o_rail_en[1]) ? cnt + 1 : 0;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt <= 0;
    end else begin
      cnt <= next_cnt;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sw_ab_on_a: assert property ($rose(i_control_input_4) |-> ##3
    o_load_switch_a_one_en && o_load_switch_b_one_en) else $error("a1/b1");
  sw_b2_on_a: assert property ($rose(i_control_input_5) |-> ##3
    o_load_switch_b_two_en) else $error("b2 not on");
  gpo_low_a: assert property ($fell(i_control_input_1) |-> ##3
    o_general_output_oe[1:0] == 2'h3) else $error("gpo not low");
  aux_rb_a: assert property (i_aux_wr |=> o_aux == $past(i_aux_data))
    else $error("aux readback");
  lin_two_a: assert property (i_aux_wr |-> ##2
    o_linear_reg_a_two_en == $past(i_aux_data.lin_a_two_en, 2))
    else $error("linear a2");
  cfg_wr_a: assert property (i_cfg_wr && !i_cfg_sleep &&
    i_cfg_rail == 3'h1 |-> ##2 o_rail_cfg[1] == $past(i_cfg_data, 2))
    else $error("cfg write");
  step_fix_a: assert property (1'b1 |=> $stable(o_rail_step))
    else $error("step changed");
  off_early_a: assert property ($fell(o_rail_en[2]) &&
    !$past(o_rail_en[1]) |-> cnt >= OFF_DLY_CYC - 2) else $error("r3 early");
  off_late_a: assert property (cnt <= OFF_DLY_CYC + 3)
    else $error("r3 late");
endmodule

// ==== prc_rail_model.sv ====
`timescale 1ns/1ps
module prc_rail_model (
  // Clock and rail enables
  input  wire logic       i_clk,
  input  wire logic [5:0] i_en,
  // Power-good back to the sequencer
  output logic [5:0]      o_pgood = 6'h00
);
  logic [5:0] ramp = 6'h00;
  // Good two cycles after enable, lost one cycle after disable
  always @(posedge i_clk) begin
    ramp <= i_en;
    o_pgood <= i_en & ramp;
  end
endmodule

// ==== tb.sv ====
`timescale 1ns/1ps
module tb;
  logic                         clk = 1'b0;
  logic                         rst = 1'b1;
  logic [5:0]                   pin = 6'h00;
  logic                         wr = 1'b0;
  logic                         slp = 1'b0;
  logic                         awr = 1'b0;
  logic [2:0]                   rail = 3'h0;
  prc_pkg::prc_rail_cfg_s       cd = '0;
  prc_pkg::prc_aux_s            ad = '0;
  prc_pkg::prc_aux_s            ax = '0;
  prc_pkg::prc_rail_cfg_s [5:0] cm =
    {6{prc_pkg::FORCE_PWM_RST, prc_pkg::VID_DEF}};
  logic [6:0]                   sv = prc_pkg::VID_SLP_DEF;
  logic [5:0]                   en, pg, step, l;
  prc_pkg::prc_rail_cfg_s [5:0] cfg;
  logic [3:0]                   oe, go;
  logic                         term;
  prc_pkg::prc_aux_s            aux;
  logic [80:0]                  q[$];
  event                         look;
  int                           error_cnt = 0;
  int                           checks_done = 0;
  int                           cyc = 0;
  always #2.5 clk = ~clk;
  prc_rail_model rail_u (.i_clk(clk), .i_en(en), .o_pgood(pg));
  prc_sequencer #(.OFF_DLY_CYC(8), .STEP_RANGE(6'h2A)) dut_u (
    .i_clk(clk), .i_rst(rst), .i_control_input_1(pin[0]),
    .i_control_input_2(pin[1]), .i_control_input_3(pin[2]),
    .i_control_input_4(pin[3]), .i_control_input_5(pin[4]),
    .i_sleep_control_input(pin[5]), .i_rail_pgood(pg), .i_cfg_wr(wr),
    .i_cfg_rail(rail), .i_cfg_sleep(slp), .i_cfg_data(cd), .i_aux_wr(awr),
    .i_aux_data(ad), .o_rail_en(en), .o_rail_cfg(cfg), .o_rail_step(step),
    .o_termination_regulator_en(term), .o_load_switch_a_one_en(l[5]),
    .o_load_switch_b_one_en(l[4]), .o_load_switch_b_two_en(l[3]),
    .o_linear_reg_a_one_en(l[2]), .o_linear_reg_a_two_en(l[1]),
    .o_linear_reg_a_three_en(l[0]), .o_general_output(go),
    .o_general_output_oe(oe), .o_aux(aux));
  // ----------------------------------------------------------------
  // Expected outputs and comparison
  // ----------------------------------------------------------------
  function automatic logic [80:0] expv();
    logic [5:0] e;
    prc_pkg::prc_rail_cfg_s [5:0] c;
    e = pin[0] ? (pin[1] ? 6'h3F : 6'h01) : 6'h00;
    c = cm;
    if (pin[5]) c[5].vid = sv;
    return {c, e, pin[2], pin[3], pin[3], pin[4] | ax.switch_b_two_en,
      ax.lin_a_one_en, ax.lin_a_two_en, ax.lin_a_three_en,
      ~ax.general_output_4_release, ~ax.general_output_3_release, ~(pin[0] & e[5]),
      ~(pin[0] & e[0]), 4'h0, ax, 6'h2A};
  endfunction
  task automatic chk(input logic [80:0] s, input logic [80:0] e);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  always @(look)
    chk({cfg, en, term, l, oe, go, aux, step}, q.pop_front());
  task automatic note(input int n);
    repeat (n) @(negedge clk);
    q.push_back(expv());
    -> look;
  endtask
  task automatic cw(input logic [2:0] r, input logic s,
                    input prc_pkg::prc_rail_cfg_s d);
    @(negedge clk);
    wr = 1'b1;
    rail = r;
    slp = s;
    cd = d;
    @(negedge clk);
    wr = 1'b0;
    if (r < 3'h6 && !s) cm[r] = d;
    if (r == 3'h5 && s) sv = d.vid;
  endtask
  task automatic aw(input prc_pkg::prc_aux_s d);
    @(negedge clk);
    awr = 1'b1;
    ad = d;
    @(negedge clk);
    awr = 1'b0;
    ax = d;
  endtask
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h24E1));
    repeat (5) @(negedge clk);
    rst = 1'b0;
    note(1);
    pin = 6'h1F;
    note(80);
    for (int i = 0; i < 8; i++) begin
      cw(i[2:0], 1'b0, prc_pkg::prc_rail_cfg_s'($urandom));
    end
    cw(3'h5, 1'b1, prc_pkg::prc_rail_cfg_s'($urandom));
    note(3);
    pin[5] = 1'b1;
    note(4);
    repeat (4) begin
      aw(prc_pkg::prc_aux_s'($urandom));
      note(3);
    end
    pin[4:2] = 3'h0;
    note(4);
    pin[0] = 1'b0;
    note(120);
    pin[0] = 1'b1;
    note(80);
    pin[1:0] = 2'h0;
    note(16);
    report_and_stop();
  end
endmodule
bind prc_sequencer prc_seq_assertions #(.OFF_DLY_CYC(OFF_DLY_CYC))
  chk_u (.*);
